// ---- rtc_calendar_dual_alarm.sv ----
// Calendar registers (date, month, year) and two alarm units of the clock.
// Assumes the timekeeping fields arrive from logic on clk_sys, and that the
// register port master follows the one-cycle strobe protocol.
`include "rtc_calendar_alarm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Date register BCD, bits 7-6 zero, reset 01
// - Month bit 5 is read-only leap-year flag
// - Month BCD tens bit 4, reset 01
// - Year two BCD digits, reset 01
// - Two identical independent alarm units; unit 1's polarity bit does not steer the pin, unit 0's serves both
// - Flag set when selected fields match and the unit's control enable bit is set
// - Flag sticky; re-set if match persists
// - Mask code selects compared fields; 101/110 reserved
// - Alarm enabled, no square wave: pin alarm mode
// - Seconds match BCD, bit 7 zero, reset 0
// - Minutes match BCD, bit 7 zero, reset 0
// - Alarm hours bit 6 mirrors clock format
// - Hour encoding depends on 12/24 format
// - Match values stored and compared as BCD
// - Flag never written to 1; register write clears
// - Mask bits 6-4, flag bit 3, polarity 7
// - Hours compare covers bits 5-0 incl. afternoon bit; format bit 6 not compared
// - Control bits 5/4 enable alarm 1/0
module rtc_calendar_dual_alarm (
	input  wire logic       clk_sys,        // System clock, 250 MHz
	input  wire logic       rst,            // Asynchronous reset, active high
	input  wire logic [4:0] reg_addr,       // Register address
	input  wire logic [7:0] reg_wdata,      // Write data
	input  wire logic       reg_wr,         // Write strobe
	input  wire logic       reg_rd,         // Read strobe
	output var  logic [7:0] reg_rdata_r,    // Read data, cycle after strobe
	input  wire logic [6:0] tk_seconds,     // Timekeeping seconds, BCD
	input  wire logic [6:0] tk_minutes,     // Timekeeping minutes, BCD
	input  wire logic [6:0] tk_hours,       // Timekeeping hours, bit 6 = 12-hour
	input  wire logic [2:0] tk_weekday,     // Timekeeping weekday
	input  wire logic       square_wave,    // Square wave from clock divider
	output var  logic       multi_function_pin_o_r,  // Pin output value, always low
	output var  logic       multi_function_pin_oe_r, // Pin drive enable, high pulls the pin low
	output var  logic [1:0] alarm_flag_r    // Alarm match flags
);

	// Every check in this module samples on the system clock and pauses in reset
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Calendar storage
	logic [5:0] cal_date_r;                 // Date tens/ones
	logic [4:0] cal_month_r;                // Month tens/ones
	logic [7:0] cal_year_r;                 // Year tens/ones
	logic [7:0] control_r;                  // Control register

	// Alarm storage, one entry per unit
	logic [6:0] alm_sec_r   [2];            // Seconds match
	logic [6:0] alm_min_r   [2];            // Minutes match
	logic [5:0] alm_hour_r  [2];            // Hours match, format bit not stored
	logic       alm_pol_r   [2];            // Output polarity
	logic [2:0] alm_sel_r   [2];            // Comparison select
	logic [2:0] alm_wday_r  [2];            // Weekday match
	logic [5:0] alm_date_r  [2];            // Date match
	logic [4:0] alm_month_r [2];            // Month match

	// Derived signals
	logic       leap_year_flag;             // Current year is a leap year
	logic [1:0] alarm_match;                // Unit enabled and selected fields equal, per unit
	logic [1:0] flag_clear;                 // Weekday/mask write, per unit
	logic [7:0] reg_rdata_nxt;              // Read mux
	rtc_calendar_alarm_pkg::pin_mode_type pin_mode; // Pin function

	// Leap year from a two-digit BCD year: multiples of four
	function automatic logic leap_of(input logic [7:0] yr);
		if (yr[4] == 1'b0) begin
			leap_of = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
		end else begin
			leap_of = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
		end
	endfunction : leap_of

	// Compare one alarm unit against the running time, straight BCD equality
	function automatic logic match_of(
		input logic [2:0] sel,
		input logic [6:0] a_sec,
		input logic [6:0] a_min,
		input logic [5:0] a_hour,
		input logic [2:0] a_wday,
		input logic [5:0] a_date,
		input logic [4:0] a_month,
		input logic [6:0] t_sec,
		input logic [6:0] t_min,
		input logic [6:0] t_hour,
		input logic [2:0] t_wday,
		input logic [5:0] t_date,
		input logic [4:0] t_month
	);
		logic s_eq;
		logic m_eq;
		logic h_eq;
		s_eq = (a_sec == t_sec);
		m_eq = (a_min == t_min);
		// Bits 5-0 hold afternoon+tens in 12-hour mode, two tens bits in 24-hour
		h_eq = (a_hour == t_hour[5:0]);
		case (sel)
			rtc_calendar_alarm_pkg::CMP_SECONDS: match_of = s_eq;
			rtc_calendar_alarm_pkg::CMP_MINUTES: match_of = m_eq;
			rtc_calendar_alarm_pkg::CMP_HOURS:   match_of = h_eq;
			rtc_calendar_alarm_pkg::CMP_WEEKDAY: match_of = (a_wday == t_wday);
			rtc_calendar_alarm_pkg::CMP_DATE:    match_of = (a_date == t_date);
			rtc_calendar_alarm_pkg::CMP_ALL:     match_of = s_eq && m_eq && h_eq &&
				(a_wday == t_wday) && (a_date == t_date) && (a_month == t_month);
			// Reserved codes never match
			default:                             match_of = 1'b0;
		endcase
	endfunction : match_of

	// Leap flag follows the stored year
	always_comb begin
		leap_year_flag = leap_of(cal_year_r);
	end

	// Calendar registers; date and month counting belong to the timekeeper
	// Digits are stored unchecked, so an invalid value is kept as written
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cal_date_r  <= `RST_CAL_DATE;
			cal_month_r <= `RST_CAL_MONTH;
			cal_year_r  <= `RST_CAL_YEAR;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFS_CAL_DATE:  cal_date_r  <= reg_wdata[5:0];
				// Leap bit is not stored, so writes to it vanish
				`OFS_CAL_MONTH: cal_month_r <= reg_wdata[4:0];
				`OFS_CAL_YEAR:  cal_year_r  <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Control register; bits 7-4 steer the pin and enable the alarms, bits 3-0 are storage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			control_r <= `RST_CONTROL;
		end else if (reg_wr && (reg_addr == `OFS_CONTROL)) begin
			control_r <= reg_wdata;
		end
	end

	// Per-unit logic; both units are built from the same description
	for (genvar u = 0; u < 2; u++) begin : g_alarm
		localparam logic [4:0] OFS_SEC   = (u == 0) ? `OFS_ALM0_SECONDS : `OFS_ALM1_SECONDS;
		localparam logic [4:0] OFS_MIN   = (u == 0) ? `OFS_ALM0_MINUTES : `OFS_ALM1_MINUTES;
		localparam logic [4:0] OFS_HOUR  = (u == 0) ? `OFS_ALM0_HOURS   : `OFS_ALM1_HOURS;
		localparam logic [4:0] OFS_WDAY  = (u == 0) ? `OFS_ALM0_WEEKDAY : `OFS_ALM1_WEEKDAY;
		localparam logic [4:0] OFS_DATE  = (u == 0) ? `OFS_ALM0_DATE    : `OFS_ALM1_DATE;
		localparam logic [4:0] OFS_MONTH = (u == 0) ? `OFS_ALM0_MONTH   : `OFS_ALM1_MONTH;
		localparam int         EN_BIT    = (u == 0) ? `BIT_ALM0_ENABLE  : `BIT_ALM1_ENABLE;

		// Match registers of this unit
		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				alm_sec_r[u]   <= 7'h00;
				alm_min_r[u]   <= 7'h00;
				alm_hour_r[u]  <= 6'h00;
				alm_pol_r[u]   <= 1'b0;
				alm_sel_r[u]   <= 3'h0;
				alm_wday_r[u]  <= `RST_ALM_WEEKDAY;
				alm_date_r[u]  <= `RST_ALM_DATE;
				alm_month_r[u] <= `RST_ALM_MONTH;
			end else if (reg_wr) begin
				// BCD stored as written; invalid digits are the host's concern
				if (reg_addr == OFS_SEC) begin
					alm_sec_r[u] <= reg_wdata[6:0];
				end
				if (reg_addr == OFS_MIN) begin
					alm_min_r[u] <= reg_wdata[6:0];
				end
				if (reg_addr == OFS_HOUR) begin
					alm_hour_r[u] <= reg_wdata[5:0];
				end
				if (reg_addr == OFS_WDAY) begin
					alm_pol_r[u]  <= reg_wdata[`BIT_ALARM_POLARITY];
					alm_sel_r[u]  <= reg_wdata[6:4];
					alm_wday_r[u] <= reg_wdata[2:0];
				end
				if (reg_addr == OFS_DATE) begin
					alm_date_r[u] <= reg_wdata[5:0];
				end
				if (reg_addr == OFS_MONTH) begin
					alm_month_r[u] <= reg_wdata[4:0];
				end
			end
		end

		// Match is checked every cycle, so each seconds update is seen at once
		always_comb begin
			alarm_match[u] = control_r[EN_BIT] && match_of(alm_sel_r[u], alm_sec_r[u],
				alm_min_r[u], alm_hour_r[u], alm_wday_r[u], alm_date_r[u], alm_month_r[u],
				tk_seconds, tk_minutes, tk_hours, tk_weekday, cal_date_r, cal_month_r);
			flag_clear[u] = reg_wr && (reg_addr == OFS_WDAY);
		end

		// Sticky flag; a match in the clearing cycle wins, so a persisting
		// match re-raises the flag and no event is lost
		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				alarm_flag_r[u] <= 1'b0;
			end else begin
				alarm_flag_r[u] <= alarm_match[u] || (alarm_flag_r[u] && !flag_clear[u]);
			end
		end

		AST_FLAG_SET: assert property (alarm_match[u] |=> alarm_flag_r[u])
			else $error("alarm flag missed a match");
		AST_FLAG_CLEAR: assert property (flag_clear[u] && !alarm_match[u] |=> !alarm_flag_r[u])
			else $error("weekday/mask write did not clear the flag");
		AST_FLAG_HOLD: assert property (alarm_flag_r[u] && !flag_clear[u] |=> alarm_flag_r[u])
			else $error("alarm flag dropped without a clear");
		AST_NO_SELF_SET: assert property (!alarm_flag_r[u] && !alarm_match[u] |=> !alarm_flag_r[u])
			else $error("alarm flag rose without a match");
		AST_RESERVED: assert property ((alm_sel_r[u] == rtc_calendar_alarm_pkg::CMP_RSVD5 ||
			alm_sel_r[u] == rtc_calendar_alarm_pkg::CMP_RSVD6) |-> !alarm_match[u])
			else $error("reserved comparison code matched");
		AST_DISABLED: assert property (!control_r[EN_BIT] |-> !alarm_match[u])
			else $error("disabled alarm matched");
	end : g_alarm

	// Pin mode: square wave has priority over the alarm function
	always_comb begin
		if (control_r[`BIT_SQW_ENABLE]) begin
			pin_mode = rtc_calendar_alarm_pkg::PIN_SQUARE;
		end else if (control_r[`BIT_ALM0_ENABLE] || control_r[`BIT_ALM1_ENABLE]) begin
			pin_mode = rtc_calendar_alarm_pkg::PIN_ALARM;
		end else begin
			pin_mode = rtc_calendar_alarm_pkg::PIN_GENERAL;
		end
	end

	// Open-drain pin: only a low level is driven, a high is left to the pull-up.
	// In alarm mode unit 0's polarity governs both flags of enabled units.
	// Limitation: unit 1's polarity bit is stored and read back but never steers the pin
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			multi_function_pin_o_r  <= 1'b0;
			multi_function_pin_oe_r <= 1'b0;
		end else begin
			multi_function_pin_o_r <= 1'b0;
			unique case (pin_mode)
				rtc_calendar_alarm_pkg::PIN_SQUARE:  multi_function_pin_oe_r <= !square_wave;
				rtc_calendar_alarm_pkg::PIN_ALARM: begin
					// Asserted level equals polarity; drive low for a low level
					multi_function_pin_oe_r <= ((alarm_flag_r[0] && control_r[`BIT_ALM0_ENABLE]) ||
						(alarm_flag_r[1] && control_r[`BIT_ALM1_ENABLE])) != alm_pol_r[0];
				end
				rtc_calendar_alarm_pkg::PIN_GENERAL: multi_function_pin_oe_r <= !control_r[`BIT_OUT_LEVEL];
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			`OFS_CAL_DATE:     reg_rdata_nxt = {2'b00, cal_date_r};
			`OFS_CAL_MONTH:    reg_rdata_nxt = {2'b00, leap_year_flag, cal_month_r};
			`OFS_CAL_YEAR:     reg_rdata_nxt = cal_year_r;
			`OFS_CONTROL:      reg_rdata_nxt = control_r;
			`OFS_ALM0_SECONDS: reg_rdata_nxt = {1'b0, alm_sec_r[0]};
			`OFS_ALM0_MINUTES: reg_rdata_nxt = {1'b0, alm_min_r[0]};
			`OFS_ALM0_HOURS:   reg_rdata_nxt = {1'b0, tk_hours[`BIT_HOUR_FORMAT], alm_hour_r[0]};
			`OFS_ALM0_WEEKDAY: reg_rdata_nxt = {alm_pol_r[0], alm_sel_r[0], alarm_flag_r[0], alm_wday_r[0]};
			`OFS_ALM0_DATE:    reg_rdata_nxt = {2'b00, alm_date_r[0]};
			`OFS_ALM0_MONTH:   reg_rdata_nxt = {3'b000, alm_month_r[0]};
			`OFS_ALM1_SECONDS: reg_rdata_nxt = {1'b0, alm_sec_r[1]};
			`OFS_ALM1_MINUTES: reg_rdata_nxt = {1'b0, alm_min_r[1]};
			`OFS_ALM1_HOURS:   reg_rdata_nxt = {1'b0, tk_hours[`BIT_HOUR_FORMAT], alm_hour_r[1]};
			`OFS_ALM1_WEEKDAY: reg_rdata_nxt = {alm_pol_r[1], alm_sel_r[1], alarm_flag_r[1], alm_wday_r[1]};
			`OFS_ALM1_DATE:    reg_rdata_nxt = {2'b00, alm_date_r[1]};
			`OFS_ALM1_MONTH:   reg_rdata_nxt = {3'b000, alm_month_r[1]};
			default:           reg_rdata_nxt = 8'h00;
		endcase
	end

	// Read data register; holds zero outside the answer cycle
	// Zero between answers keeps a stale word from passing for a fresh one
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata_r <= 8'h00;
		end else begin
			reg_rdata_r <= reg_rd ? reg_rdata_nxt : 8'h00;
		end
	end

	// Register port and pin checks

	AST_DATE_READ: assert property (reg_rd && reg_addr == `OFS_CAL_DATE
		|=> reg_rdata_r == {2'b00, $past(cal_date_r)})
		else $error("date read value wrong");
	AST_LEAP_READ: assert property (reg_rd && reg_addr == `OFS_CAL_MONTH
		|=> reg_rdata_r[`BIT_LEAP_YEAR] == leap_of($past(cal_year_r)) && reg_rdata_r[7:6] == 2'b00)
		else $error("leap flag read wrong");
	AST_LEAP_WRITE: assert property (reg_wr && reg_addr == `OFS_CAL_MONTH
		|=> cal_month_r == $past(reg_wdata[4:0]))
		else $error("month write stored wrong bits");
	AST_MONTH_READ: assert property (reg_rd && reg_addr == `OFS_CAL_MONTH
		|=> reg_rdata_r[4:0] == $past(cal_month_r))
		else $error("month read value wrong");
	AST_YEAR_WRITE: assert property (reg_wr && reg_addr == `OFS_CAL_YEAR
		|=> cal_year_r == $past(reg_wdata))
		else $error("year write did not land");

	AST_HOUR_MIRROR: assert property (reg_rd && reg_addr == `OFS_ALM0_HOURS
		|=> reg_rdata_r[`BIT_HOUR_FORMAT] == $past(tk_hours[`BIT_HOUR_FORMAT]) && !reg_rdata_r[7])
		else $error("hours format bit not mirrored");
	AST_HOUR1_MIRROR: assert property (reg_rd && reg_addr == `OFS_ALM1_HOURS
		|=> reg_rdata_r[`BIT_HOUR_FORMAT] == $past(tk_hours[`BIT_HOUR_FORMAT])
		&& reg_rdata_r[5:0] == $past(alm_hour_r[1]))
		else $error("second unit hours read wrong");
	AST_SEC_READ: assert property (reg_rd && reg_addr == `OFS_ALM1_SECONDS
		|=> reg_rdata_r == {1'b0, $past(alm_sec_r[1])})
		else $error("seconds match read wrong");
	AST_MIN_READ: assert property (reg_rd && reg_addr == `OFS_ALM0_MINUTES
		|=> reg_rdata_r == {1'b0, $past(alm_min_r[0])})
		else $error("minutes match read wrong");
	AST_WDAY0_READ: assert property (reg_rd && reg_addr == `OFS_ALM0_WEEKDAY
		|=> reg_rdata_r[`BIT_ALARM_FLAG] == $past(alarm_flag_r[0]) && reg_rdata_r[6:4] == $past(alm_sel_r[0]))
		else $error("first unit mask register read wrong");
	AST_WDAY1_READ: assert property (reg_rd && reg_addr == `OFS_ALM1_WEEKDAY
		|=> reg_rdata_r[`BIT_ALARM_FLAG] == $past(alarm_flag_r[1]) && reg_rdata_r[6:4] == $past(alm_sel_r[1]))
		else $error("second unit mask register read wrong");

	AST_PIN_ALARM: assert property (!control_r[`BIT_SQW_ENABLE] && control_r[`BIT_ALM0_ENABLE]
		&& alarm_flag_r[0] && !alm_pol_r[0] |=> multi_function_pin_oe_r)
		else $error("pin not asserted low on alarm");
	AST_PIN_GENERAL: assert property (pin_mode == rtc_calendar_alarm_pkg::PIN_GENERAL
		|=> multi_function_pin_oe_r == !$past(control_r[`BIT_OUT_LEVEL]))
		else $error("general output level wrong");
	AST_PIN_SQUARE: assert property (control_r[`BIT_SQW_ENABLE]
		|=> multi_function_pin_oe_r == !$past(square_wave))
		else $error("square wave not passed to the pin");

endmodule : rtc_calendar_dual_alarm

`default_nettype wire

// ---- rtc_calendar_alarm_cfg.svh ----
// Register offsets, field positions and reset values for the calendar and
// dual alarm block. Assumes an 8-bit register port with a 5-bit address.
`ifndef RTC_CALENDAR_ALARM_CFG_SVH
`define RTC_CALENDAR_ALARM_CFG_SVH

// Register offsets
`define OFS_CAL_DATE        5'h04
`define OFS_CAL_MONTH       5'h05
`define OFS_CAL_YEAR        5'h06
`define OFS_CONTROL         5'h07
`define OFS_ALM0_SECONDS    5'h0A
`define OFS_ALM0_MINUTES    5'h0B
`define OFS_ALM0_HOURS      5'h0C
`define OFS_ALM0_WEEKDAY    5'h0D
`define OFS_ALM0_DATE       5'h0E
`define OFS_ALM0_MONTH      5'h0F
`define OFS_ALM1_SECONDS    5'h11
`define OFS_ALM1_MINUTES    5'h12
`define OFS_ALM1_HOURS      5'h13
`define OFS_ALM1_WEEKDAY    5'h14
`define OFS_ALM1_DATE       5'h15
`define OFS_ALM1_MONTH      5'h16

// Field positions
`define BIT_LEAP_YEAR       5
`define BIT_HOUR_FORMAT     6
`define BIT_ALARM_FLAG      3
`define BIT_ALARM_POLARITY  7
`define BIT_OUT_LEVEL       7
`define BIT_SQW_ENABLE      6
`define BIT_ALM1_ENABLE     5
`define BIT_ALM0_ENABLE     4

// Reset values
`define RST_CAL_DATE        6'h01
`define RST_CAL_MONTH       5'h01
`define RST_CAL_YEAR        8'h01
`define RST_CONTROL         8'h80
`define RST_ALM_WEEKDAY     3'h1
`define RST_ALM_DATE        6'h01
`define RST_ALM_MONTH       5'h01

`endif

// ---- rtc_calendar_alarm_pkg.sv ----
// Types shared by the calendar and dual alarm block.
// Assumes nothing beyond a SystemVerilog compiler.
package rtc_calendar_alarm_pkg;

	// Alarm comparison selection codes
	typedef enum logic [2:0] {
		CMP_SECONDS = 3'h0,
		CMP_MINUTES = 3'h1,
		CMP_HOURS   = 3'h2,
		CMP_WEEKDAY = 3'h3,
		CMP_DATE    = 3'h4,
		CMP_RSVD5   = 3'h5,
		CMP_RSVD6   = 3'h6,
		CMP_ALL     = 3'h7
	} compare_select_type;

	// Multi-function pin modes, one-hot
	typedef enum logic [2:0] {
		PIN_GENERAL = 3'h1,
		PIN_ALARM   = 3'h2,
		PIN_SQUARE  = 3'h4
	} pin_mode_type;

endpackage : rtc_calendar_alarm_pkg

// ---- reg_host_model.sv ----
// Host-side master of the register port: one-cycle write and read strobes.
// Assumes one calling process and a clock shared with the block.
`timescale 1ns/1ps
`default_nettype none

module reg_host_model (
	input  wire logic       clk_sys,   // System clock
	output var  logic [4:0] reg_addr,  // Register address
	output var  logic [7:0] reg_wdata, // Write data
	output var  logic       reg_wr,    // Write strobe
	output var  logic       reg_rd     // Read strobe
);
	// Idle bus at time zero
	initial begin
		reg_addr  = 5'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// Released lines show the inverse, so a stale value never passes for a live one
	task automatic drop(input logic [4:0] a, input logic [7:0] d);
		reg_wr    <= 1'b0;
		reg_rd    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : drop

	// One write cycle; callers pass only valid BCD digits to match registers
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		drop(a, d);
	endtask : wr

	// One read cycle; the data are sampled by the bench the cycle after
	task automatic rd(input logic [4:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		drop(a, reg_wdata);
	endtask : rd
endmodule : reg_host_model

`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the calendar and dual alarm block.
// Assumes the register host model drives the port; the bench drives the time fields.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_calendar_alarm_cfg.svh"

module tb;
	logic       clk_sys;     // 250 MHz clock
	logic       rst;         // Active-high reset
	logic [4:0] reg_addr;    // Port address
	logic [7:0] reg_wdata;   // Port write data
	logic       reg_wr;      // Write strobe
	logic       reg_rd;      // Read strobe
	logic [7:0] reg_rdata_r; // Read data
	logic [6:0] tk_seconds;  // Time fields fed to the alarms
	logic [6:0] tk_minutes;
	logic [6:0] tk_hours;
	logic [2:0] tk_weekday;
	logic       square_wave; // Divider output
	logic       multi_function_pin_o_r;  // Pin value
	logic       multi_function_pin_oe_r; // Pin drive enable
	logic [1:0] alarm_flag_r; // Alarm flags
	logic       rd_d;        // Read taken last edge
	logic [7:0] exp_q [$];   // Expected read data, oldest first
	int         n_fail;
	int         cmp_count;
	// Reset values: {address, data}
	localparam logic [12:0] RST_TAB [17] = '{13'h0401, 13'h0501, 13'h0601, 13'h0780, 13'h0A00, 13'h0B00,
		13'h0C00, 13'h0D01, 13'h0E01, 13'h0F01, 13'h1100, 13'h1200, 13'h1300, 13'h1401, 13'h1501, 13'h1601,
		13'h1F00};
	// Readback: {address, implemented mask, top tens digit}
	localparam logic [16:0] RW_TAB [11] = '{{5'h04, 8'h3F, 4'd3}, {5'h05, 8'h1F, 4'd1},
		{5'h06, 8'hFF, 4'd9}, {5'h0A, 8'h7F, 4'd5}, {5'h0B, 8'h7F, 4'd5}, {5'h0E, 8'h3F, 4'd3},
		{5'h0F, 8'h1F, 4'd1}, {5'h11, 8'h7F, 4'd5}, {5'h12, 8'h7F, 4'd5}, {5'h15, 8'h3F, 4'd3},
		{5'h16, 8'h1F, 4'd1}};

	rtc_calendar_dual_alarm i_rtc_calendar_dual_alarm (
		.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .tk_seconds(tk_seconds), .tk_minutes(tk_minutes),
		.tk_hours(tk_hours), .tk_weekday(tk_weekday), .square_wave(square_wave),
		.multi_function_pin_o_r(multi_function_pin_o_r), .multi_function_pin_oe_r(multi_function_pin_oe_r),
		.alarm_flag_r(alarm_flag_r));

	reg_host_model i_reg_host_model (
		.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

	// Free-running clock, 4 ns period
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// Single comparison point; case equality so unknowns never match
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Verdict and end of run
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test

	// Notes the expectation, then issues the read
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		i_reg_host_model.rd(a);
	endtask : rd

	// Lets settled outputs be sampled a fixed number of edges later
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : idle

	// Read data stand only in the cycle after the strobe, so compare then
	always @(posedge clk_sys) begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1 && exp_q.size() > 0) begin
			check("rdata", reg_rdata_r, exp_q.pop_front());
		end
	end

	// Hang guard well above the planned run
	initial begin
		#400000;
		n_fail++;
		stop_test();
	end

	initial begin : main
		logic [7:0] b;
		logic [4:0] wk;
		logic [4:0] base;
		logic       hit;
		rst = 1'b1;
		n_fail = 0;
		cmp_count = 0;
		tk_seconds = 7'h45;
		tk_minutes = 7'h30;
		tk_hours = 7'h00;
		tk_weekday = 3'd3;
		square_wave = 1'b0;
		void'($urandom(32'hE2B9DC66));
		idle(2);
		rst <= 1'b0;
		foreach (RST_TAB[i]) rd(RST_TAB[i][12:8], RST_TAB[i][7:0]);
		// Random BCD with unimplemented and read-only bits set on the way in
		foreach (RW_TAB[i]) begin
			b = {4'($urandom_range(int'(RW_TAB[i][3:0]), 0)), 4'($urandom_range(9, 0))};
			i_reg_host_model.wr(RW_TAB[i][16:12], b | ~RW_TAB[i][11:4]);
			rd(RW_TAB[i][16:12], b);
		end
		i_reg_host_model.wr(`OFS_CAL_MONTH, 8'h12);
		i_reg_host_model.wr(`OFS_CAL_YEAR, 8'h24);
		rd(`OFS_CAL_MONTH, 8'h32);
		i_reg_host_model.wr(`OFS_CAL_MONTH, 8'h08);
		i_reg_host_model.wr(`OFS_CAL_YEAR, 8'h23);
		rd(`OFS_CAL_MONTH, 8'h08);
		i_reg_host_model.wr(5'h1F, 8'h5A);
		rd(5'h1F, 8'h00);
		i_reg_host_model.wr(`OFS_CAL_DATE, 8'h15);
		tk_hours <= 7'h72;
		for (int u = 0; u < 2; u++) begin
			base = (u == 0) ? `OFS_ALM0_SECONDS : `OFS_ALM1_SECONDS;
			wk = base + 5'd3;
			i_reg_host_model.wr(base + 5'd2, 8'hF2);
			rd(base + 5'd2, 8'h72);
			for (int c = 0; c < 8; c++) begin
				hit = (c != 5) && (c != 6);
				// Setup order: disable, mask and polarity with flag write, match values, enable
				i_reg_host_model.wr(`OFS_CONTROL, 8'h00);
				i_reg_host_model.wr(wk, {1'b0, 3'(c), 1'b1, 3'd3});
				i_reg_host_model.wr(base, 8'h45);
				i_reg_host_model.wr(base + 5'd1, 8'h30);
				i_reg_host_model.wr(base + 5'd4, 8'h15);
				i_reg_host_model.wr(base + 5'd5, 8'h08);
				check("flag_off", {7'h00, alarm_flag_r[u]}, 8'h00);
				i_reg_host_model.wr(`OFS_CONTROL, (u == 0) ? 8'h10 : 8'h20);
				idle(3);
				check("flag_set", {7'h00, alarm_flag_r[u]}, {7'h00, hit});
				check("flag_other", {7'h00, alarm_flag_r[1 - u]}, 8'h00);
				check("pin_alarm", {7'h00, multi_function_pin_oe_r}, {7'h00, hit});
				if (hit) begin
					i_reg_host_model.wr(wk, {1'b0, 3'(c), 1'b0, 3'd3});
					idle(2);
					check("flag_reset", {7'h00, alarm_flag_r[u]}, 8'h01);
					rd(wk, {1'b0, 3'(c), 1'b1, 3'd3});
				end
				if (c == 2) begin
					tk_hours <= 7'h52;
					i_reg_host_model.wr(wk, {1'b0, 3'(c), 1'b0, 3'd3});
					idle(2);
					check("flag_am", {7'h00, alarm_flag_r[u]}, 8'h00);
					tk_hours <= 7'h72;
				end
				if (c == 0) begin
					tk_seconds <= 7'h46;
					idle(3);
					check("flag_sticky", {7'h00, alarm_flag_r[u]}, 8'h01);
					i_reg_host_model.wr(wk, {1'b0, 3'(c), 1'b0, 3'd3});
					idle(2);
					check("flag_clear", {7'h00, alarm_flag_r[u]}, 8'h00);
					tk_seconds <= 7'h45;
				end
			end
			// Disable and clear this unit so its sticky flag cannot leak into the next unit's checks
			i_reg_host_model.wr(`OFS_CONTROL, 8'h00);
			i_reg_host_model.wr(wk, 8'h03);
			idle(2);
			check("flag_cleared", {7'h00, alarm_flag_r[u]}, 8'h00);
		end
		// General output, then square wave overriding both enables
		i_reg_host_model.wr(`OFS_CONTROL, 8'h80);
		idle(3);
		check("pin_general", {7'h00, multi_function_pin_oe_r}, 8'h00);
		i_reg_host_model.wr(`OFS_CONTROL, 8'h70);
		square_wave <= 1'b1;
		idle(3);
		check("pin_square_hi", {7'h00, multi_function_pin_oe_r}, 8'h00);
		square_wave <= 1'b0;
		idle(3);
		check("pin_square_lo", {7'h00, multi_function_pin_oe_r}, 8'h01);
		check("pin_value", {7'h00, multi_function_pin_o_r}, 8'h00);
		idle(3);
		stop_test();
	end
endmodule : tb

`default_nettype wire
